//--- rtl/transducer_status_registers.sv
// Status register bank of the power transducer with AXI4-Lite access
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "xdcr_defines.svh"

module transducer_status_registers
    import xdcr_pkg::*;
#(
    parameter int WPROT_HOLD = `WPROT_HOLD_CYC
) (
    input  wire logic        aclk,      // System clock, 20 MHz
    input  wire logic        aresetn,   // Synchronous reset, low
    input  wire logic [15:0] awaddr,    // Write address
    input  wire logic        awvalid,   // Write address valid
    output logic             awready,   // Write address ready
    input  wire logic [31:0] wdata,     // Write data
    input  wire logic [3:0]  wstrb,     // Write byte strobes
    input  wire logic        wvalid,    // Write data valid
    output logic             wready,    // Write data ready
    output logic [1:0]       bresp,     // Write response
    output logic             bvalid,    // Write response valid
    input  wire logic        bready,    // Write response ready
    input  wire logic [15:0] araddr,    // Read address
    input  wire logic        arvalid,   // Read address valid
    output logic             arready,   // Read address ready
    output logic [31:0]      rdata,     // Read data
    output logic [1:0]       rresp,     // Read response
    output logic             rvalid,    // Read data valid
    input  wire logic        rready,    // Read data ready
    input  wire alarm_in_t   alarm_in,  // Alarm relays, lamps, overrun
    input  wire card_in_t    card_in,   // Memory card handler events
    input  wire meas_in_t    meas_in,   // Measurement flags
    input  wire net_in_t     net_in,    // Network interface flags
    output logic             irq        // Level interrupt
);

    ////////////////////////////////////////////////////////////////////
    // Byte addresses

    localparam logic [15:0] A_SECOND  = {`IDX_SECOND, 2'b00};
    localparam logic [15:0] A_CARD    = {`IDX_CARD, 2'b00};
    localparam logic [15:0] A_MEAS    = {`IDX_MEAS, 2'b00};
    localparam logic [15:0] A_NET     = {`IDX_NET, 2'b00};
    localparam logic [15:0] A_SPARE   = {`IDX_SPARE, 2'b00};
    localparam logic [15:0] A_EVT     = {`IDX_EVT, 2'b00};
    localparam logic [15:0] A_EVT_CLR = {`IDX_EVT_CLR, 2'b00};
    localparam logic [15:0] A_EVT_EN  = {`IDX_EVT_EN, 2'b00};
    localparam logic [19:0] WP_LAST   = 20'(WPROT_HOLD - 1);

    ////////////////////////////////////////////////////////////////////
    // Declarations

    logic [15:0]  second_ff;
    logic [15:0]  nxt_second;
    logic [15:0]  meas_ff;
    logic [15:0]  net_ff;
    logic [15:0]  card_ff;
    logic [15:0]  evt_ff;
    logic [15:0]  evt_en_ff;
    card_state_t  card_st_ff;
    card_state_t  nxt_card_st;
    logic [19:0]  wp_cnt_ff;
    logic         awready_ff;
    logic         wready_ff;
    logic         aw_held_ff;
    logic         w_held_ff;
    logic [15:0]  wr_addr_ff;
    logic [15:0]  wr_data_ff;
    logic [1:0]   wr_strb_ff;
    logic         bvalid_ff;
    logic [1:0]   bresp_ff;
    logic         arready_ff;
    logic         rvalid_ff;
    logic [31:0]  rdata_ff;
    logic [1:0]   rresp_ff;
    logic         irq_ff;
    logic         do_wr;
    logic         wr_hit;
    logic [15:0]  wr_mask;
    logic [15:0]  evt_clr;
    logic [15:0]  evt_set;
    logic [15:0]  rd_word;
    logic         rd_hit;
    logic         wp_done;

    ////////////////////////////////////////////////////////////////////
    // Second status word

    // Live state of alarms and overrun; unused bits stay zero
    always_comb begin
        nxt_second = `REG_RST;
        nxt_second[`SS_RELAY1] = alarm_in.alarm_one_relay;
        nxt_second[`SS_RELAY2] = alarm_in.alarm_two_relay;
        nxt_second[`SS_LAMP1]  = alarm_in.alarm_one_lamp;
        nxt_second[`SS_LAMP2]  = alarm_in.alarm_two_lamp;
        nxt_second[`SS_OVR1]   = alarm_in.out1_ovr_en;
    end

    // Refreshed every cycle from the inputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            second_ff <= `REG_RST;
        end else begin
            second_ff <= nxt_second;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Measurement status

    // Bits 1 to 6 and 11 to 15 are reserved and hold zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meas_ff <= `REG_RST;
        end else begin
            meas_ff <= `REG_RST;
            meas_ff[`MS_SYNC_CUR] <= meas_in.sync_on_current;
            meas_ff[`MS_U_LOW]    <= meas_in.volt_low;
            meas_ff[`MS_I_LOW]    <= meas_in.curr_low;
            meas_ff[`MS_U_HIGH]   <= meas_in.volt_high;
            meas_ff[`MS_I_HIGH]   <= meas_in.curr_high;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Network interface status

    // Unfitted units read only zeros, so a
    // floating handler cannot show health
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            net_ff <= `REG_RST;
        end else begin
            net_ff <= `REG_RST;
            net_ff[`NS_FITTED] <= net_in.fitted;
            if (net_in.fitted) begin
                net_ff[`NS_ANEG_RUN] <= net_in.aneg_running;
                net_ff[`NS_ANEG_OK]  <= net_in.aneg_done;
                net_ff[`NS_LINK]     <= net_in.link_up;
                net_ff[`NS_DHCP_OK]  <= net_in.dhcp_ok;
                net_ff[`NS_DHCP_RNW] <= net_in.dhcp_renew;
                net_ff[`NS_CABLE]    <= net_in.cable_ok;
                net_ff[`NS_FTP]      <= net_in.ftp_ok;
                net_ff[`NS_PWR_SAVE] <= net_in.power_save;
                net_ff[`NS_IF_CLK]   <= net_in.if_clk_ok;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Memory card state machine

    assign wp_done = (wp_cnt_ff == WP_LAST);

    // Card removal wins from any state
    always_comb begin
        nxt_card_st = card_st_ff;
        unique case (card_st_ff)
            CS_ABSENT: begin
                if (card_in.present) begin
                    nxt_card_st = CS_LOOSE;
                end
            end
            CS_LOOSE, CS_FAILED: begin
                if (card_in.install_req) begin
                    nxt_card_st = CS_BUSY;
                end
            end
            CS_BUSY: begin
                if (card_in.install_fail) begin
                    nxt_card_st = CS_FAILED;
                end else if (card_in.install_ok) begin
                    nxt_card_st = card_in.write_prot ? CS_WPROT
                                                     : CS_READY;
                end
            end
            CS_READY, CS_FULL: begin
                if (card_in.write_prot) begin
                    nxt_card_st = CS_WPROT;
                end else begin
                    nxt_card_st = card_in.full ? CS_FULL : CS_READY;
                end
            end
            CS_WPROT: begin
                if (wp_done) begin
                    nxt_card_st = CS_LOOSE;
                end
            end
            default: begin
                nxt_card_st = CS_ABSENT;
            end
        endcase
        if (!card_in.present) begin
            nxt_card_st = CS_ABSENT;
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            card_st_ff <= CS_ABSENT;
        end else begin
            card_st_ff <= nxt_card_st;
        end
    end

    // Code 3 stands for the hold time so software can see it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wp_cnt_ff <= 20'h0_0000;
        end else if (card_st_ff != CS_WPROT || wp_done) begin
            wp_cnt_ff <= 20'h0_0000;
        end else begin
            wp_cnt_ff <= wp_cnt_ff + 20'h0_0001;
        end
    end

    // Visible code follows the state one cycle later
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            card_ff <= `CARD_ABSENT;
        end else begin
            unique case (card_st_ff)
                CS_ABSENT: card_ff <= `CARD_ABSENT;
                CS_LOOSE:  card_ff <= `CARD_LOOSE;
                CS_FAILED: card_ff <= `CARD_FAILED;
                CS_WPROT:  card_ff <= `CARD_WPROT;
                CS_READY:  card_ff <= `CARD_READY;
                CS_FULL:   card_ff <= `CARD_FULL;
                CS_BUSY:   card_ff <= `CARD_BUSY;
                default:   card_ff <= `CARD_ABSENT;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel

    assign do_wr = aw_held_ff && w_held_ff && !bvalid_ff;

    // Address and data are taken in either order and held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b1;
            aw_held_ff <= 1'b0;
            wr_addr_ff <= 16'h0000;
        end else if (awvalid && awready_ff) begin
            awready_ff <= 1'b0;
            aw_held_ff <= 1'b1;
            wr_addr_ff <= awaddr;
        end else if (bvalid_ff && bready) begin
            awready_ff <= 1'b1;
            aw_held_ff <= 1'b0;
        end
    end

    // Only the low half carries register bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_ff  <= 1'b1;
            w_held_ff  <= 1'b0;
            wr_data_ff <= 16'h0000;
            wr_strb_ff <= 2'h0;
        end else if (wvalid && wready_ff) begin
            wready_ff  <= 1'b0;
            w_held_ff  <= 1'b1;
            wr_data_ff <= wdata[15:0];
            wr_strb_ff <= wstrb[1:0];
        end else if (bvalid_ff && bready) begin
            wready_ff  <= 1'b1;
            w_held_ff  <= 1'b0;
        end
    end

    // Read-only targets take writes with no effect
    always_comb begin
        unique case (wr_addr_ff)
            A_SECOND, A_CARD, A_MEAS, A_NET, A_SPARE,
            A_EVT, A_EVT_CLR, A_EVT_EN: wr_hit = 1'b1;
            default:                    wr_hit = 1'b0;
        endcase
    end

    assign wr_mask = {{8{wr_strb_ff[1]}}, {8{wr_strb_ff[0]}}};

    // Response one cycle after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= `RESP_OKAY;
        end else if (do_wr) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bvalid_ff && bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Event status, clear and enable

    // Rising alarm and overrun bits are events
    assign evt_set = nxt_second & ~second_ff & `SS_EVT_MASK;
    assign evt_clr = (do_wr && wr_addr_ff == A_EVT_CLR)
                   ? (wr_data_ff & wr_mask) : 16'h0000;

    // Sticky; a new event beats a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_ff <= `REG_RST;
        end else begin
            evt_ff <= (evt_ff & ~evt_clr) | evt_set;
        end
    end

    // Enable keeps only event-capable bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_en_ff <= `REG_RST;
        end else if (do_wr && wr_addr_ff == A_EVT_EN) begin
            evt_en_ff <= ((evt_en_ff & ~wr_mask)
                       | (wr_data_ff & wr_mask)) & `SS_EVT_MASK;
        end
    end

    // Level output; one cycle behind the status it reflects
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(evt_ff & evt_en_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel

    // Spare register and the write-only clear read as zero
    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 16'h0000;
        unique case (araddr)
            A_SECOND:  rd_word = second_ff;
            A_CARD:    rd_word = card_ff;
            A_MEAS:    rd_word = meas_ff;
            A_NET:     rd_word = net_ff;
            A_SPARE:   rd_word = 16'h0000;
            A_EVT:     rd_word = evt_ff;
            A_EVT_CLR: rd_word = 16'h0000;
            A_EVT_EN:  rd_word = evt_en_ff;
            default:   rd_hit  = 1'b0;
        endcase
    end

    // One read in flight; address is refused until data is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= `RESP_OKAY;
        end else if (arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= {16'h0000, rd_word};
            rresp_ff   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid_ff && rready) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    assign awready = awready_ff;
    assign wready  = wready_ff;
    assign bvalid  = bvalid_ff;
    assign bresp   = bresp_ff;
    assign arready = arready_ff;
    assign rvalid  = rvalid_ff;
    assign rdata   = rdata_ff;
    assign rresp   = rresp_ff;
    assign irq     = irq_ff;

endmodule // transducer_status_registers

//--- rtl/xdcr_defines.svh
// Register indices, field positions, codes and timing of the status block
`ifndef XDCR_DEFINES_SVH
`define XDCR_DEFINES_SVH

// Register indices; byte address is four times the index
`define IDX_SECOND   14'h10cf
`define IDX_CARD     14'h10d0
`define IDX_MEAS     14'h10d1
`define IDX_NET      14'h10d2
`define IDX_SPARE    14'h10d3
`define IDX_EVT      14'h10d4
`define IDX_EVT_CLR  14'h10d5
`define IDX_EVT_EN   14'h10d6

// Second status word fields
`define SS_RELAY1    0
`define SS_RELAY2    1
`define SS_LAMP1     4
`define SS_LAMP2     5
`define SS_OVR1      6
`define SS_EVT_MASK  16'h0073

// Measurement status fields
`define MS_SYNC_CUR  0
`define MS_U_LOW     7
`define MS_I_LOW     8
`define MS_U_HIGH    9
`define MS_I_HIGH    10

// Network interface status fields
`define NS_FITTED    0
`define NS_ANEG_RUN  1
`define NS_ANEG_OK   2
`define NS_LINK      3
`define NS_DHCP_OK   4
`define NS_DHCP_RNW  5
`define NS_CABLE     6
`define NS_FTP       7
`define NS_PWR_SAVE  8
`define NS_IF_CLK    10

// Memory card state codes
`define CARD_ABSENT  16'h0000
`define CARD_LOOSE   16'h0001
`define CARD_FAILED  16'h0002
`define CARD_WPROT   16'h0003
`define CARD_READY   16'h0004
`define CARD_FULL    16'h0005
`define CARD_BUSY    16'h0006

// Bus answers and reset values
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`define REG_RST      16'h0000

// Time that code 3 stands before the card is uninstalled
`define WPROT_HOLD_NS 1000000
`define CLK_PERIOD_NS 50
`define WPROT_HOLD_CYC (`WPROT_HOLD_NS / `CLK_PERIOD_NS)

`endif

//--- rtl/xdcr_pkg.sv
// Types shared by the transducer status register block
package xdcr_pkg;

    // Alarm outputs and analog output options seen by the status word
    typedef struct packed {
        logic alarm_one_relay;
        logic alarm_two_relay;
        logic alarm_one_lamp;
        logic alarm_two_lamp;
        logic out1_ovr_en;
    } alarm_in_t;

    // Memory card events and levels from the card handler
    typedef struct packed {
        logic present;
        logic install_req;
        logic install_ok;
        logic install_fail;
        logic write_prot;
        logic full;
    } card_in_t;

    // Measurement synchronisation and threshold flags
    typedef struct packed {
        logic sync_on_current;
        logic volt_low;
        logic curr_low;
        logic volt_high;
        logic curr_high;
    } meas_in_t;

    // Network interface health
    typedef struct packed {
        logic fitted;
        logic aneg_running;
        logic aneg_done;
        logic link_up;
        logic dhcp_ok;
        logic dhcp_renew;
        logic cable_ok;
        logic ftp_ok;
        logic power_save;
        logic if_clk_ok;
    } net_in_t;

    // Memory card states
    typedef enum logic [2:0] {
        CS_ABSENT,
        CS_LOOSE,
        CS_FAILED,
        CS_WPROT,
        CS_READY,
        CS_FULL,
        CS_BUSY
    } card_state_t;

endpackage

//--- sim/status_checker_assertions.sv
// Port-level checks of the transducer status register block
`timescale 1ns/10ps
`include "xdcr_defines.svh"

module status_checker
    import xdcr_pkg::*;
(
    input wire logic        aclk,     // Clock
    input wire logic        aresetn,  // Reset, low
    input wire logic        awvalid,  // AW valid
    input wire logic        awready,  // AW ready
    input wire logic        wvalid,   // W valid
    input wire logic        wready,   // W ready
    input wire logic        bvalid,   // B valid
    input wire logic [15:0] araddr,   // AR address
    input wire logic        arvalid,  // AR valid
    input wire logic        arready,  // AR ready
    input wire logic [31:0] rdata,    // R data
    input wire logic [1:0]  rresp,    // R response
    input wire logic        rvalid,   // R valid
    input wire logic        rready,   // R ready
    input wire alarm_in_t   alarm_in, // Alarm inputs
    input wire meas_in_t    meas_in,  // Measurement inputs
    input wire net_in_t     net_in    // Network inputs
);
    localparam logic [15:0] A_SEC  = {`IDX_SECOND, 2'h0};
    localparam logic [15:0] A_MEAS = {`IDX_MEAS, 2'h0};
    localparam logic [15:0] A_NET  = {`IDX_NET, 2'h0};
    localparam logic [15:0] A_HI   = {`IDX_EVT_EN, 2'h0};

    logic [15:0] sec_exp;
    logic [15:0] meas_exp;
    logic [15:0] net_exp;

    // Expected images from the inputs, by field position
    assign sec_exp  = {9'h000, alarm_in[0], alarm_in[1], alarm_in[2], 2'h0,
                       alarm_in[3], alarm_in[4]};
    assign meas_exp = {5'h00, meas_in[0], meas_in[1], meas_in[2], meas_in[3],
                       6'h00, meas_in[4]};
    // Without the option fitted every network bit reads zero
    assign net_exp  = net_in.fitted ? {5'h00, net_in.if_clk_ok, 1'b0,
                       net_in.power_save, net_in.ftp_ok, net_in.cable_ok,
                       net_in.dhcp_renew, net_in.dhcp_ok, net_in.link_up,
                       net_in.aneg_done, net_in.aneg_running, 1'b1} : 16'h0000;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_rd_take;
        arvalid && arready;
    endsequence
    sequence s_wr_take;
        awvalid && awready && wvalid && wready;
    endsequence
    // Inputs steady two edges, so the register has caught up
    sequence s_steady_rd(logic [15:0] a, logic [15:0] x);
        s_rd_take ##0 (araddr == a && $past(aresetn) && $past(aresetn, 2)
            && $stable(x) && $past(x) == $past(x, 2));
    endsequence

    ////////////////////////////////////////////////////////////////////////
    a_read_answer: assert property (
        s_rd_take |=> rvalid && !arready)
        else $error("read answer late");
    a_ready_back: assert property (
        rvalid && rready |=> !rvalid && arready)
        else $error("read channel not freed");
    a_write_answer: assert property (
        s_wr_take |=> (!awready && !wready) ##1 bvalid)
        else $error("write answer late");
    a_read_upper: assert property (
        rvalid |-> rdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    a_unmapped_err: assert property (
        s_rd_take ##0 (araddr < A_SEC || araddr > A_HI)
        |=> rresp == `RESP_SLVERR && rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    a_second_map: assert property (
        s_steady_rd(A_SEC, sec_exp) |=> rdata[15:0] == $past(sec_exp))
        else $error("second status word wrong");
    a_meas_map: assert property (
        s_steady_rd(A_MEAS, meas_exp) |=> rdata[15:0] == $past(meas_exp))
        else $error("measurement status wrong");
    a_net_map: assert property (
        s_steady_rd(A_NET, net_exp) |=> rdata[15:0] == $past(net_exp))
        else $error("network status wrong");
endmodule // status_checker

bind transducer_status_registers status_checker status_checker_i (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .alarm_in(alarm_in),
    .meas_in(meas_in), .net_in(net_in));

//--- sim/tb_top.sv
// Self-checking bench of the transducer status register block
`timescale 1ns/10ps
`include "xdcr_defines.svh"

module tb_top;
    import xdcr_pkg::*;

    localparam int HOLD = 40;  // Short hold keeps the run brief
    localparam logic [15:0] A_SEC = {`IDX_SECOND, 2'h0};
    localparam logic [15:0] A_CRD = {`IDX_CARD, 2'h0};
    localparam logic [15:0] A_MEA = {`IDX_MEAS, 2'h0};
    localparam logic [15:0] A_NET = {`IDX_NET, 2'h0};
    localparam logic [15:0] A_SPR = {`IDX_SPARE, 2'h0};
    localparam logic [15:0] A_EVT = {`IDX_EVT, 2'h0};
    localparam logic [15:0] A_CLR = {`IDX_EVT_CLR, 2'h0};
    localparam logic [15:0] A_EN  = {`IDX_EVT_EN, 2'h0};

    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [15:0] awaddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0]  wstrb = '0;
    logic [15:0] araddr = '0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    alarm_in_t   alarm_in = '0;
    card_in_t    card_in = '0;
    meas_in_t    meas_in = '0;
    net_in_t     net_in = '0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    int          err_total = 0;
    int          checks_done = 0;

    transducer_status_registers #(.WPROT_HOLD(HOLD))
        transducer_status_registers_i (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .alarm_in(alarm_in),
        .card_in(card_in), .meas_in(meas_in), .net_in(net_in), .irq(irq));

    always #25 aclk = ~aclk;

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string s, input logic [31:0] v, e);
        checks_done++;
        if (v !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", s, e, v);
        end
    endtask

    // Offers both channels; drops each when taken
    task automatic wr(input string s, input logic [15:0] a, d,
                      input logic [1:0] er = `RESP_OKAY);
        bit aw = 0, w = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        wstrb <= 4'h3;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (aw && w && bvalid === 1'b1) begin
                bready <= 1'b0;
                break;
            end
            if (!aw && awready === 1'b1) begin
                aw = 1;
                awvalid <= 1'b0;
            end
            if (!w && wready === 1'b1) begin
                w = 1;
                wvalid <= 1'b0;
            end
        end
        check({s, " bresp"}, 32'(bresp), 32'(er));
    endtask

    // Address held until taken; data judged at the edge rvalid is seen
    task automatic rd(input string s, input logic [15:0] a, e,
                      input logic [1:0] er = `RESP_OKAY);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        check(s, rdata, {16'h0000, e});
        check({s, " rresp"}, 32'(rresp), 32'(er));
        rready <= 1'b0;
    endtask

    // Inputs reach the registers within two edges
    task automatic settle();
        repeat (3) @(posedge aclk);
    endtask

    task automatic card_to(input logic [5:0] c, input logic [15:0] code);
        card_in <= card_in_t'(c);
        @(posedge aclk);
        card_in <= card_in_t'(c & 6'h23);  // Requests last one cycle only
        settle();
        rd("card state", A_CRD, code);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [15:0] a [8] = '{A_SEC, A_CRD, A_MEA, A_NET, A_SPR, A_EVT,
                               A_CLR, A_EN};
        for (int i = 0; i < 8; i++) begin
            rd("after reset", a[i], 16'h0000);
        end
        rd("unmapped", 16'h4400, 16'h0000, `RESP_SLVERR);
        wr("unmapped", 16'h4400, 16'hffff, `RESP_SLVERR);
        $display("reset test done, %0d wrong", err_total);
    endtask

    task automatic t_walk();
        logic [15:0] ea [5] = '{16'h0040, 16'h0020, 16'h0010, 16'h0002,
                                16'h0001};
        logic [15:0] em [5] = '{16'h0400, 16'h0200, 16'h0100, 16'h0080,
                                16'h0001};
        logic [15:0] en [9] = '{16'h0401, 16'h0101, 16'h0081, 16'h0041,
                                16'h0021, 16'h0011, 16'h0009, 16'h0005,
                                16'h0003};
        for (int i = 0; i < 5; i++) begin
            alarm_in <= alarm_in_t'(5'h01 << i);
            meas_in <= meas_in_t'(5'h01 << i);
            settle();
            rd("second", A_SEC, ea[i]);
            rd("meas", A_MEA, em[i]);
        end
        for (int i = 0; i < 9; i++) begin
            net_in <= net_in_t'(10'h200 | (10'h001 << i));
            settle();
            rd("n", A_NET, en[i]);
        end
        net_in <= net_in_t'(10'h1ff);
        settle();
        rd("net absent", A_NET, 16'h0000);
        alarm_in <= '1;
        meas_in <= '1;
        net_in <= '1;
        wr("second", A_SEC, 16'h0000);
        wr("spare", A_SPR, 16'hffff);
        rd("second all", A_SEC, 16'h0073);
        rd("meas all", A_MEA, 16'h0781);
        rd("net all", A_NET, 16'h05ff);
        rd("spare", A_SPR, 16'h0000);
        alarm_in <= '0;
        $display("walk test done, %0d wrong", err_total);
    endtask

    task automatic t_card();
        card_to(6'h20, `CARD_LOOSE);
        card_to(6'h30, `CARD_BUSY);
        card_to(6'h24, `CARD_FAILED);
        card_to(6'h30, `CARD_BUSY);
        card_to(6'h28, `CARD_READY);
        card_to(6'h21, `CARD_FULL);
        card_to(6'h20, `CARD_READY);
        card_to(6'h22, `CARD_WPROT);
        repeat (HOLD) @(posedge aclk);
        rd("uninstalled", A_CRD, `CARD_LOOSE);
        card_to(6'h00, `CARD_ABSENT);
        $display("card test done, %0d wrong", err_total);
    endtask

    task automatic t_events();
        settle();
        wr("clear all", A_CLR, 16'h0073);
        wr("enable", A_EN, 16'hffff);
        rd("enable", A_EN, 16'h0073);
        rd("no event", A_EVT, 16'h0000);
        alarm_in <= alarm_in_t'(5'h10);
        settle();
        alarm_in <= '0;
        settle();
        rd("sticky", A_EVT, 16'h0001);
        check("irq on", 32'(irq), 32'h1);
        wr("mask", A_EN, 16'h0010);
        settle();
        check("irq masked", 32'(irq), 32'h0);
        alarm_in <= alarm_in_t'(5'h04);
        settle();
        check("irq lamp", 32'(irq), 32'h1);
        wr("clear", A_CLR, 16'h0011);
        settle();
        check("irq clear", 32'(irq), 32'h0);
        rd("cleared", A_EVT, 16'h0000);
        rd("clear reg", A_CLR, 16'h0000);
        $display("event test done, %0d wrong", err_total);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Watchdog; the tests need under 2000 cycles
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        tally_and_finish();
    end

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_walk();
        t_card();
        t_events();
        tally_and_finish();
    end
endmodule // tb_top
